// file: logic/exs_pkg.sv
// Package for the execute-remote sequencer: constants, states, carriers.
// Assumes a 24-bit storage address and 64-bit doubleword data paths.
package exs_pkg;

    // ************************************************************
    // Codes and fields
    // ************************************************************
    localparam logic [7:0] EXS_OP_EXEC = 8'h44;
    localparam logic [7:0] EXS_RR_MASK = 8'hc0;
    localparam logic [2:0] EXS_OPND_BYTE = 3'h7;
    localparam logic [23:0] EXS_DW_STEP = 24'h000008;
    localparam logic [23:0] EXS_IC_BACK = 24'h000008;
    localparam logic [1:0] EXS_LAST_HW = 2'h3;
    localparam logic [3:0] EXS_NO_MOD = 4'h0;

    // ************************************************************
    // Register port map (byte addresses) and reset values
    // ************************************************************
    localparam logic [3:0] EXS_CTRL_OFS = 4'h0;
    localparam logic [3:0] EXS_STAT_OFS = 4'h4;
    localparam logic [31:0] EXS_CTRL_RST = 32'h00000001;
    localparam int EXS_CTRL_EN_BIT = 0;
    localparam int EXS_CTRL_CLR_BIT = 1;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        EXS_IDLE = 4'b0000,
        EXS_CHECK = 4'b0001,
        EXS_SETUP = 4'b0010,
        EXS_WAIT = 4'b0011,
        EXS_FORMAT = 4'b0100,
        EXS_MODIFY = 4'b0101,
        EXS_REQ_NEXT = 4'b0110,
        EXS_WAIT_NEXT = 4'b0111,
        EXS_REQ_IC = 4'b1000,
        EXS_FINISH = 4'b1001
    } exs_state_type;

    // Storage request carrier
    typedef struct packed {
        logic valid;
        logic [23:0] addr;
    } exs_sreq_type;

endpackage : exs_pkg

// file: logic/exs_sequencer.sv
// Execute-remote instruction sequencer with a small register port.
// Assumes storage answers each request with one storage_data_valid pulse
// carrying the doubleword, and that all inputs are synchronous to ref_clk.
//
// Contract
// - Modified subject ORs its bits 8-15 with operand bits 56-63.
// - First register field zero means no modification, else modify.
// - Subject that is itself execute raises execute interruption, suppresses.
// - Odd effective address raises specification interruption, suppresses.
// - Execute is recognised by operation code 44.
// - Subject instructions of 16, 32 or 48 bits are accepted.
// - Entry holds subject address, issued request, operand and first halfword.
// - Execute flag is set marking next instruction as subject.
// - Stale-prefetch flag is set so prefetch buffer gets refilled.
// - Stale-prefetch flag forces exceptional branch at the first fetch with hold state clear.
// - Pending interruptions end with normal end-op, else branch end-op.
// - Operand byte counter loads 111, selecting operand bits 56-63.
// - Subject address plus 8 is written back.
// - Adder result bits 21-23 load the fetched byte counter.
// - Address bits 21-22 equal 11 means subject in last halfword.
// - Opcode AND 11000000 equal zero means register-to-register format.
// - Last-halfword register-to-register subject issues no further request.
// - Longer last-halfword subject requests next doubleword, waits, loads buffer.
// - Longer case backs off instruction counter and requests that doubleword.
// - Modification ORs fetched byte with last operand byte, moves to decode.
// - No interruption moves decode to instruction register and holds.
// - Address bits 21-22 not 11 issue no request, continue as RR.
//
// Design decisions made here: strobed register access and the address map.
module exs_sequencer
    import exs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [15:0] instr_in,
    input wire logic [63:0] operand_in,
    input wire logic [23:0] subject_addr_in,
    input wire logic [23:0] ic_in,
    input wire logic prog_int_pending,
    input wire logic storage_data_valid,
    input wire logic [63:0] storage_data_out,
    input wire logic ifetch_start,
    input wire logic subject_done,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output exs_sreq_type storage_req,
    output logic [15:0] instr_reg,
    output logic [63:0] operand_pair_registers,
    output logic [23:0] instruction_counter,
    output logic [63:0] prefetch_buf,
    output logic execute_flag,
    output logic stale_prefetch_flag,
    output logic exceptional_branch_condition,
    output logic hold_state,
    output logic end_op_normal,
    output logic end_op_branch,
    output logic prog_int_cycle,
    output logic int_execute,
    output logic int_spec,
    output logic busy,
    output logic [31:0] reg_rdata
);

    // ************************************************************
    // State and datapath registers
    // ************************************************************
    exs_state_type state_r;
    exs_sreq_type sreq_r;
    logic [15:0] instr_r, decode_r;
    logic [63:0] opnd_r, pair_r, qbuf_r;
    logic [23:0] addr_r, ic_r, parallel_adder_result;
    logic [2:0] operand_byte_counter_r, fetched_byte_counter_r;
    logic [7:0] serial_adder_result_r, fetched_byte, opnd_byte, op_byte;
    logic last_hw_r, modify_r, suppress_r, exec_r, stale_r, excb_r, hold_r, busy_r;
    logic eon_r, eob_r, pic_r, iex_r, isp_r;
    logic [31:0] ctrl_r, rdata_r;
    logic end_now, int_now, take;

    // Byte selects into the fetched pair and operand pair, byte 0 leftmost
    assign fetched_byte = pair_r[8'(63 - 8 * int'(fetched_byte_counter_r)) -: 8];
    assign opnd_byte = opnd_r[8'(63 - 8 * int'(operand_byte_counter_r)) -: 8];
    // Opcode of the subject as found on the data bus
    assign op_byte = storage_data_out[8'(63 - 8 * int'(addr_r[2:0])) -: 8];
    assign parallel_adder_result = addr_r + EXS_DW_STEP;
    assign end_now = (state_r == EXS_FINISH);
    assign int_now = prog_int_pending | suppress_r;
    // accept only opcode 44 while idle and enabled
    assign take = (state_r == EXS_IDLE) && start && ctrl_r[EXS_CTRL_EN_BIT]
        && instr_in[15:8] == EXS_OP_EXEC;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= EXS_IDLE;
            busy_r <= 1'b0;
        end else begin
            // Busy follows the state being entered
            busy_r <= take || (state_r != EXS_IDLE && state_r != EXS_FINISH);
            case (state_r)
                EXS_IDLE: begin
                    if (take) begin
                        state_r <= EXS_CHECK;
                    end
                end
                EXS_CHECK: begin
                    state_r <= addr_r[0] ? EXS_FINISH : EXS_SETUP;
                end
                EXS_SETUP: begin
                    state_r <= EXS_WAIT;
                end
                EXS_WAIT: begin
                    if (storage_data_valid) begin
                        state_r <= (op_byte == EXS_OP_EXEC) ? EXS_FINISH : EXS_FORMAT;
                    end
                end
                EXS_FORMAT: begin
                    state_r <= EXS_MODIFY;
                end
                EXS_MODIFY: begin
                    // RR or not-last halfword needs no request
                    if (last_hw_r && serial_adder_result_r != 8'h00) begin
                        state_r <= EXS_REQ_NEXT;
                    end else begin
                        state_r <= EXS_FINISH;
                    end
                end
                EXS_REQ_NEXT: begin
                    state_r <= EXS_WAIT_NEXT;
                end
                EXS_WAIT_NEXT: begin
                    if (storage_data_valid) begin
                        state_r <= EXS_REQ_IC;
                    end
                end
                EXS_REQ_IC: begin
                    state_r <= EXS_FINISH;
                end
                EXS_FINISH: begin
                    state_r <= EXS_IDLE;
                end
                default: begin
                    state_r <= EXS_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Entry capture, address update and counters
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addr_r <= 24'h000000;
            operand_byte_counter_r <= 3'h0;
            fetched_byte_counter_r <= 3'h0;
            last_hw_r <= 1'b0;
            modify_r <= 1'b0;
        end else if (take) begin
            // entry state captured from the fetch stage
            addr_r <= subject_addr_in;
            modify_r <= (instr_in[7:4] != EXS_NO_MOD);
        end else if (state_r == EXS_SETUP) begin
            operand_byte_counter_r <= EXS_OPND_BYTE;
            addr_r <= parallel_adder_result;
            // low adder bits pick the subject byte
            fetched_byte_counter_r <= parallel_adder_result[2:0];
            last_hw_r <= (addr_r[2:1] == EXS_LAST_HW);
        end else if (state_r == EXS_FORMAT) begin
            fetched_byte_counter_r <= fetched_byte_counter_r + 3'h1;
        end
    end

    // ************************************************************
    // Operand, fetched pair and decode path
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            opnd_r <= 64'h0;
            pair_r <= 64'h0;
            decode_r <= 16'h0;
            instr_r <= 16'h0;
            serial_adder_result_r <= 8'h00;
        end else begin
            if (take) begin
                opnd_r <= operand_in;
                instr_r <= instr_in;
            end
            // whole doubleword kept so 48-bit subjects decode
            if (state_r == EXS_WAIT && storage_data_valid) begin
                pair_r <= storage_data_out;
            end
            if (state_r == EXS_FORMAT) begin
                // RR format when opcode AND mask is zero
                serial_adder_result_r <= fetched_byte & EXS_RR_MASK;
                decode_r[15:8] <= fetched_byte;
            end
            if (state_r == EXS_MODIFY) begin
                if (modify_r) begin
                    // OR subject bits 8-15 with operand bits 56-63
                    // result back to operand pair and decode
                    opnd_r[7:0] <= fetched_byte | opnd_byte;
                    decode_r[7:0] <= fetched_byte | opnd_byte;
                end else begin
                    decode_r[7:0] <= fetched_byte;
                end
            end
            if (end_now && !int_now) begin
                instr_r <= decode_r;
            end
        end
    end

    // ************************************************************
    // Storage requests, instruction counter, prefetch buffer
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sreq_r <= '0;
            ic_r <= 24'h000000;
            qbuf_r <= 64'h0;
        end else begin
            sreq_r.valid <= 1'b0;
            if (take) begin
                ic_r <= ic_in;
            end
            if (state_r == EXS_WAIT && storage_data_valid) begin
                qbuf_r <= storage_data_out;
            end
            if (state_r == EXS_REQ_NEXT) begin
                sreq_r.valid <= 1'b1;
                sreq_r.addr <= addr_r;
            end
            if (state_r == EXS_WAIT_NEXT && storage_data_valid) begin
                qbuf_r <= storage_data_out;
                ic_r <= ic_r - EXS_IC_BACK;
            end
            if (state_r == EXS_REQ_IC) begin
                // fetch the doubleword after the execute
                sreq_r.valid <= 1'b1;
                sreq_r.addr <= ic_r;
            end
        end
    end

    // ************************************************************
    // Interruption and end-op signalling
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        iex_r <= 1'b0;
        isp_r <= 1'b0;
        eon_r <= 1'b0;
        eob_r <= 1'b0;
        pic_r <= 1'b0;
        if (srst) begin
            suppress_r <= 1'b0;
        end else begin
            if (state_r == EXS_IDLE) begin
                suppress_r <= 1'b0;
            end
            if (state_r == EXS_CHECK && addr_r[0]) begin
                isp_r <= 1'b1;
                suppress_r <= 1'b1;
            end
            if (state_r == EXS_WAIT && storage_data_valid && op_byte == EXS_OP_EXEC) begin
                iex_r <= 1'b1;
                suppress_r <= 1'b1;
            end
            if (end_now) begin
                // end-op kind chosen by pending interruptions
                eon_r <= int_now;
                eob_r <= !int_now;
                // interruption cycle when one is pending
                pic_r <= int_now;
            end
        end
    end

    // ************************************************************
    // Execute, stale-prefetch and hold flags
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            exec_r <= 1'b0;
            stale_r <= 1'b0;
            excb_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            excb_r <= 1'b0;
            // stale flag forces the exceptional branch once
            if (ifetch_start && stale_r && !hold_r) begin
                excb_r <= 1'b1;
            end
            if (subject_done || (reg_wr && reg_addr == EXS_CTRL_OFS && reg_wdata[EXS_CTRL_CLR_BIT])) begin
                exec_r <= 1'b0;
                hold_r <= 1'b0;
            end
            if ((ifetch_start && stale_r && !hold_r)
                || (reg_wr && reg_addr == EXS_CTRL_OFS && reg_wdata[EXS_CTRL_CLR_BIT])) begin
                stale_r <= 1'b0;
            end
            // Setting below wins over any clear in the same cycle
            if (end_now && !suppress_r) begin
                // mark the next instruction as subject
                exec_r <= 1'b1;
                stale_r <= 1'b1;
                hold_r <= !prog_int_pending;
            end
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_r <= EXS_CTRL_RST;
            rdata_r <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == EXS_CTRL_OFS) begin
                ctrl_r <= {31'h0, reg_wdata[EXS_CTRL_EN_BIT]};
            end
            rdata_r <= 32'h0;
            if (reg_rd && reg_addr == EXS_CTRL_OFS) begin
                rdata_r <= ctrl_r;
            end else if (reg_rd && reg_addr == EXS_STAT_OFS) begin
                rdata_r <= {20'h0, serial_adder_result_r == 8'h00, modify_r, last_hw_r, suppress_r,
                    hold_r, stale_r, exec_r, state_r != EXS_IDLE, state_r};
            end
        end
    end

    // Outputs straight from flip-flops
    assign storage_req = sreq_r;
    assign instr_reg = instr_r;
    assign operand_pair_registers = opnd_r;
    assign instruction_counter = ic_r;
    assign prefetch_buf = qbuf_r;
    assign execute_flag = exec_r;
    assign stale_prefetch_flag = stale_r;
    assign exceptional_branch_condition = excb_r;
    assign hold_state = hold_r;
    assign end_op_normal = eon_r;
    assign end_op_branch = eob_r;
    assign prog_int_cycle = pic_r;
    assign int_execute = iex_r;
    assign int_spec = isp_r;
    assign busy = busy_r;
    assign reg_rdata = rdata_r;

endmodule : exs_sequencer

// file: verif/exs_storage_model.sv
// Behavioural main storage for the execute-remote sequencer.
// Assumes requests are one-cycle pulses; kick stands for the entry request.
module exs_storage_model
    import exs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire exs_sreq_type storage_req,
    input wire logic kick,
    input wire logic [23:0] kick_addr,
    input wire logic [2:0] lat,
    output logic storage_data_valid,
    output logic [63:0] storage_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Delay line
    // ********
    logic [63:0] mem [0:7];
    logic [7:0] vld_r;
    logic [2:0] idx_r [0:7];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vld_r <= '0;
        end else begin
            vld_r <= {1'b0, vld_r[7:1]};
            for (int i = 0; i < 7; i++) begin
                idx_r[i] <= idx_r[i + 1];
            end
            if (storage_req.valid || kick) begin
                vld_r[lat - 3'h1] <= 1'b1;
                idx_r[lat - 3'h1] <= kick ? kick_addr[5:3] : storage_req.addr[5:3];
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        storage_data_valid <= !srst && vld_r[0];
        storage_data_out <= vld_r[0] ? mem[idx_r[0]] : ~storage_data_out;
    end
endmodule : exs_storage_model

// file: verif/exs_sequencer_checker.sv
// Assertions on the execute-remote sequencer ports.
// Assumes one clock domain and a synchronous active-high srst.
module exs_sequencer_checker
    import exs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [15:0] instr_in,
    input wire logic [23:0] subject_addr_in,
    input wire logic ifetch_start,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire exs_sreq_type storage_req,
    input wire logic execute_flag,
    input wire logic stale_prefetch_flag,
    input wire logic exceptional_branch_condition,
    input wire logic hold_state,
    input wire logic end_op_normal,
    input wire logic end_op_branch,
    input wire logic prog_int_cycle,
    input wire logic int_spec,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Helpers and assertions
    // ********
    logic en_r;
    logic go;
    // Mirrors the enable bit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            en_r <= 1'b1;
        end else if (reg_wr && reg_addr == EXS_CTRL_OFS) begin
            en_r <= reg_wdata[EXS_CTRL_EN_BIT];
        end
    end
    // Entry the sequencer must take
    assign go = start && !busy && en_r && instr_in[15:8] == EXS_OP_EXEC;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_start_busy: assert property (go |=> busy)
        else $error("busy not raised");
    a_wrong_op: assert property (
        start && !busy && instr_in[15:8] != EXS_OP_EXEC |=> !busy)
        else $error("wrong opcode taken");
    a_odd_spec: assert property (go && subject_addr_in[0] |-> ##[1:3] int_spec)
        else $error("no spec interruption");
    a_spec_end: assert property (
        int_spec |-> ##[0:3] (end_op_normal && prog_int_cycle))
        else $error("no interruption cycle");
    a_one_end: assert property (!(end_op_normal && end_op_branch))
        else $error("two end cycles");
    a_int_normal: assert property (prog_int_cycle |-> end_op_normal)
        else $error("int cycle without normal end");
    a_branch_hold: assert property (
        end_op_branch |-> ##[0:1] (hold_state && execute_flag && stale_prefetch_flag))
        else $error("branch end without flags");
    a_exc_fetch: assert property (
        ifetch_start && stale_prefetch_flag && !hold_state && !busy
        |-> ##[1:2] (exceptional_branch_condition && !stale_prefetch_flag))
        else $error("no exceptional branch");
    a_exc_cause: assert property (
        exceptional_branch_condition |-> $past(ifetch_start) || $past(ifetch_start, 2))
        else $error("stray exceptional branch");
    a_req_pulse: assert property (storage_req.valid |=> !storage_req.valid)
        else $error("request longer than one cycle");
    a_idle_no_req: assert property (!busy && !$past(busy) |-> !storage_req.valid)
        else $error("request while idle");
endmodule : exs_sequencer_checker

bind exs_sequencer exs_sequencer_checker u_chk (
    .ref_clk, .srst, .start, .instr_in, .subject_addr_in, .ifetch_start, .reg_addr,
    .reg_wdata, .reg_wr, .storage_req, .execute_flag, .stale_prefetch_flag,
    .exceptional_branch_condition, .hold_state, .end_op_normal, .end_op_branch,
    .prog_int_cycle, .int_spec, .busy
);

// file: verif/exs_sequencer_tb.sv
// Self-checking bench for the execute-remote sequencer.
// Assumes the storage model in exs_storage_model and the bound checker.
module exs_sequencer_tb
    import exs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Signals, design and storage
    // ********
    localparam logic [63:0] OPND = 64'h0011223344556677;
    logic ref_clk, srst, start, prog_int_pending, ifetch_start, subject_done, reg_wr, reg_rd;
    logic storage_data_valid, execute_flag, stale_prefetch_flag, exceptional_branch_condition;
    logic hold_state, end_op_normal, end_op_branch, prog_int_cycle, int_execute, int_spec;
    logic busy, kick, s_norm, s_br, s_pic, s_ix, s_is, seen;
    logic [15:0] instr_in, instr_reg;
    logic [63:0] operand_in, storage_data_out, operand_pair_registers, prefetch_buf;
    logic [23:0] subject_addr_in, ic_in, instruction_counter;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0] lat;
    exs_sreq_type storage_req;
    logic [23:0] req_q[$];
    int error_cnt, comparisons, cyc;
    exs_sequencer dut (.ref_clk, .srst, .start, .instr_in, .operand_in, .subject_addr_in,
        .ic_in, .prog_int_pending, .storage_data_valid, .storage_data_out, .ifetch_start,
        .subject_done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .storage_req, .instr_reg,
        .operand_pair_registers, .instruction_counter, .prefetch_buf, .execute_flag,
        .stale_prefetch_flag, .exceptional_branch_condition, .hold_state, .end_op_normal,
        .end_op_branch, .prog_int_cycle, .int_execute, .int_spec, .busy, .reg_rdata);
    exs_storage_model mdl (.ref_clk, .srst, .storage_req, .kick, .kick_addr(subject_addr_in),
        .lat, .storage_data_valid, .storage_data_out);
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Request log and hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (storage_req.valid) req_q.push_back(storage_req.addr);
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic test_done();
        $display("TB: errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    function automatic logic [63:0] mk(input int i, input logic [7:0] op, input logic [7:0] mb);
        logic [63:0] w;
        w = 64'h0123456789abcdef;
        w[63 - 8 * i -: 8] = op;
        w[55 - 8 * i -: 8] = mb;
        return w;
    endfunction : mk
    // ********
    // Bus and sequence helpers
    // ********
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(64'(reg_rdata & m), 64'(e), "register read");
    endtask : rd_chk
    task automatic dead_start(input logic [7:0] op);
        @(posedge ref_clk);
        start <= 1'b1;
        instr_in <= {op, 8'h00};
        @(posedge ref_clk);
        start <= 1'b0;
        @(posedge ref_clk);
        #1 chk(64'(busy), 64'h0, "start ignored");
    endtask : dead_start
    task automatic run_ex(input logic [7:0] lo, input logic [23:0] d, input logic pend,
            input logic [2:0] l);
        int n;
        wr_reg(EXS_CTRL_OFS, 32'h3);
        req_q.delete();
        {s_norm, s_br, s_pic, s_ix, s_is} = '0;
        @(posedge ref_clk);
        {start, kick, lat, prog_int_pending} <= {2'b11, l, pend};
        {instr_in, subject_addr_in, ic_in} <= {EXS_OP_EXEC, lo, d, 24'h000400};
        @(posedge ref_clk);
        {start, kick} <= 2'b00;
        for (n = 0; n < 60 && !(s_norm || s_br); n++) begin
            @(posedge ref_clk);
            #1 {s_norm, s_br, s_pic, s_ix, s_is} = {s_norm, s_br, s_pic, s_ix, s_is}
                | {end_op_normal, end_op_branch, prog_int_cycle, int_execute, int_spec};
        end
        repeat (8) @(posedge ref_clk);
        prog_int_pending <= 1'b0;
    endtask : run_ex
    task automatic fetch();
        @(posedge ref_clk);
        ifetch_start <= 1'b1;
        @(posedge ref_clk);
        ifetch_start <= 1'b0;
        #1 seen = exceptional_branch_condition;
        @(posedge ref_clk);
        #1 seen |= exceptional_branch_condition;
    endtask : fetch
    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        rd_chk(EXS_CTRL_OFS, '1, 32'h1);
        rd_chk(4'h8, '1, 32'h0);
        wr_reg(EXS_CTRL_OFS, 32'h0);
        dead_start(EXS_OP_EXEC);
        wr_reg(EXS_CTRL_OFS, 32'h1);
        dead_start(8'h45);
    endtask : t_regs
    task automatic t_short();
        mdl.mem[2] = mk(2, 8'h1a, 8'h35);
        run_ex(8'h00, 24'h000012, 1'b0, 3'h3);
        chk(64'(s_br), 64'h1, "branch end");
        chk(64'(instr_reg), 64'h1a35, "plain subject");
        chk(64'(req_q.size()), 64'h0, "no request");
        chk(prefetch_buf, mk(2, 8'h1a, 8'h35), "buffer");
        rd_chk(EXS_STAT_OFS, 32'hf0, 32'he0);
        fetch();
        chk(64'(seen), 64'h0, "held fetch");
        @(posedge ref_clk);
        subject_done <= 1'b1;
        @(posedge ref_clk);
        subject_done <= 1'b0;
        #1 chk(64'({hold_state, execute_flag}), 64'h0, "done clears");
        fetch();
        chk(64'({seen, stale_prefetch_flag}), 64'h2, "exc branch");
        mdl.mem[3] = mk(4, 8'h5a, 8'h80);
        run_ex(8'h30, 24'h00001c, 1'b0, 3'h4);
        chk(64'(instr_reg), 64'h5af7, "modified");
        chk(operand_pair_registers, {OPND[63:8], 8'hf7}, "operand byte");
        chk(64'(req_q.size()), 64'h0, "no request");
        wr_reg(EXS_CTRL_OFS, 32'h3);
        rd_chk(EXS_STAT_OFS, 32'hf0, 32'h0);
    endtask : t_short
    task automatic t_last();
        mdl.mem[4] = mk(6, 8'h18, 8'h02);
        run_ex(8'h10, 24'h000026, 1'b0, 3'h3);
        chk(64'(instr_reg), 64'h1877, "rr subject");
        chk(64'(req_q.size()), 64'h0, "rr no request");
        mdl.mem[5] = mk(6, 8'h58, 8'h40);
        mdl.mem[6] = 64'h1122334455667788;
        run_ex(8'hf0, 24'h00002e, 1'b0, 3'h6);
        chk(64'(req_q.size()), 64'h2, "two requests");
        chk(64'(req_q[0][23:3]), 64'h6, "next doubleword");
        chk(64'(req_q[1]), 64'h3f8, "counter request");
        chk(64'(instruction_counter), 64'h3f8, "counter back");
        chk(prefetch_buf, 64'h1122334455667788, "refill");
        chk(64'({instr_reg, s_br}), 64'hb0ef, "long subject");
    endtask : t_last
    task automatic t_ints();
        run_ex(8'h00, 24'h000013, 1'b0, 3'h3);
        chk(64'({s_is, s_norm, s_pic, s_br}), 64'he, "odd address");
        chk(64'(execute_flag), 64'h0, "suppressed");
        mdl.mem[1] = mk(0, EXS_OP_EXEC, 8'h00);
        run_ex(8'h00, 24'h000008, 1'b0, 3'h3);
        chk(64'({s_ix, s_norm, s_pic, execute_flag}), 64'he, "nested");
        run_ex(8'h00, 24'h000012, 1'b1, 3'h5);
        chk(64'({s_norm, s_pic, s_br, hold_state}), 64'hc, "pending");
    endtask : t_ints
    // Main sequence
    initial begin
        srst = 1'b1;
        {start, prog_int_pending, ifetch_start, subject_done, reg_wr, reg_rd, kick} = '0;
        {instr_in, subject_addr_in, ic_in, reg_addr, reg_wdata} = '0;
        operand_in = OPND;
        lat = 3'h3;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_short();
        t_last();
        t_ints();
        test_done();
    end
endmodule : exs_sequencer_tb
